// *** iossr_pkg.sv ***
// Purpose: constants and carrier types for the i/o space scratch register bank
// Assumes: 8-bit data, 9-bit data-space addresses, 6-bit i/o addresses
// Notes:   register addresses are i/o addresses; data-space address is +0x20
package iossr_pkg;

  // address space layout
  localparam logic [8:0] IOSSR_DS_OFFSET  = 9'h020;  // data space = io + 0x20
  localparam logic [8:0] IOSSR_EXT_LO     = 9'h060;  // extended region start
  localparam logic [8:0] IOSSR_EXT_HI     = 9'h1FF;  // extended region end
  localparam logic [5:0] IOSSR_BIT_IO_MAX = 6'h1F;   // last bit-accessible address
  localparam int         IOSSR_IO_LOCS    = 64;      // in/out reach

  // register i/o addresses
  localparam logic [5:0] IOSSR_ADDR_PA_IN  = 6'h00;  // port a input, reserved
  localparam logic [5:0] IOSSR_ADDR_PA_DIR = 6'h01;
  localparam logic [5:0] IOSSR_ADDR_PA_DAT = 6'h02;
  localparam logic [5:0] IOSSR_ADDR_PC_IN  = 6'h06;  // port c input, reserved
  localparam logic [5:0] IOSSR_ADDR_PC_DIR = 6'h07;
  localparam logic [5:0] IOSSR_ADDR_PC_DAT = 6'h08;
  localparam logic [5:0] IOSSR_ADDR_SCR0   = 6'h1E;
  localparam logic [5:0] IOSSR_ADDR_SCR1   = 6'h2A;
  localparam logic [5:0] IOSSR_ADDR_SCR2   = 6'h2B;

  // reset value of every storage register
  localparam logic [7:0] IOSSR_RESET_VAL = 8'h00;
  localparam int         IOSSR_NUM_REGS  = 7;

  // access kinds issued by the core
  typedef enum logic [2:0] {
    IOSSR_OP_NONE   = 3'h0,
    IOSSR_OP_MEM_RD = 3'h1,  // memory_read_ops, data-space address
    IOSSR_OP_MEM_WR = 3'h2,  // memory_write_ops, data-space address
    IOSSR_OP_IO_IN  = 3'h3,  // in, i/o address
    IOSSR_OP_IO_OUT = 3'h4,  // out, i/o address
    IOSSR_OP_BIT_SET= 3'h5,  // set_io_bit
    IOSSR_OP_BIT_CLR= 3'h6,  // clear_io_bit
    IOSSR_OP_BIT_TST= 3'h7   // skip_if_io_bit_high / skip_if_io_bit_low
  } iossr_op_t;

  // one access request from the core
  typedef struct packed {
    iossr_op_t  op;
    logic [8:0] addr;   // data-space address or i/o address by op
    logic [2:0] bitn;   // bit number for bit ops
    logic [7:0] wdata;
  } iossr_req_t;

  // answer to the core
  typedef struct packed {
    logic       hit;    // the access selected a register of this bank
    logic [7:0] rdata;
    logic       bitval; // addressed bit for skip instructions
    logic       bad;    // access not allowed for this op or address
  } iossr_rsp_t;

endpackage

// *** iossr_bank.sv ***
// Purpose: scratch storage registers in the processor i/o space
// Assumes: core issues at most one access per cycle, synchronous to clk
// Notes:   answer is registered, valid the cycle after the request
//
// What this block does
// - memory ops decode io address plus 0x20
// - in/out reach only 64 locations
// - extended region 0x60-0x1FF refused, even to memory ops
// - writes store the whole byte; no write-one-clear flags
// - bit set/clear touch only addressed bit
// - bit set/clear only at 0x00-0x1F
// - three general 8-bit scratch registers
// - low scratch register (0x1E) supports bit ops, skips
// - absent port data/direction are plain storage
// - in/out use io addresses 0x00-0x3F
`timescale 1ns/1ps
`default_nettype none

module iossr_bank
  import iossr_pkg::*;
#(
  parameter int DATA_W = 8  // register width
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // core access port
  input  wire iossr_req_t req,
  output var  iossr_rsp_t rsp
);

  // elaboration check: the storage layout is fixed at eight bits
  if (DATA_W != 8) begin : g_bad_width
    $error("iossr_bank supports DATA_W of 8 only");
  end

  // register index table, one entry per storage register
  localparam logic [5:0] REG_ADDR [IOSSR_NUM_REGS] = '{
    IOSSR_ADDR_PA_DIR, IOSSR_ADDR_PA_DAT, IOSSR_ADDR_PC_DIR,
    IOSSR_ADDR_PC_DAT, IOSSR_ADDR_SCR0, IOSSR_ADDR_SCR1, IOSSR_ADDR_SCR2
  };

  logic [7:0] store_reg  [IOSSR_NUM_REGS];  // storage contents
  logic [7:0] store_next [IOSSR_NUM_REGS];
  iossr_rsp_t rsp_reg;                       // registered answer
  iossr_rsp_t rsp_next;

  // decode helpers
  logic       is_mem;      // data-space access
  logic       is_io;       // in/out access
  logic       is_bit;      // single-bit access
  logic [5:0] io_addr;     // resolved i/o address
  logic       addr_ok;     // address legal for this op
  logic [IOSSR_NUM_REGS-1:0] sel;  // one-hot register select
  logic       rsvd_sel;    // reserved input register addressed

  // resolve the i/o address and legality for each access kind
  always_comb begin
    is_mem  = (req.op == IOSSR_OP_MEM_RD) || (req.op == IOSSR_OP_MEM_WR);
    is_io   = (req.op == IOSSR_OP_IO_IN) || (req.op == IOSSR_OP_IO_OUT);
    is_bit  = (req.op == IOSSR_OP_BIT_SET) || (req.op == IOSSR_OP_BIT_CLR)
              || (req.op == IOSSR_OP_BIT_TST);
    io_addr = 6'h00;
    addr_ok = 1'b0;
    if (is_mem) begin
      // data space maps io registers at +0x20; 0x60 and up is extended space
      if (req.addr >= IOSSR_DS_OFFSET && req.addr < IOSSR_EXT_LO) begin
        io_addr = 6'(req.addr - IOSSR_DS_OFFSET);
        addr_ok = 1'b1;
      end
    end else if (is_io) begin
      // only six address bits exist in the opcode; higher bits are a fault
      io_addr = req.addr[5:0];
      addr_ok = (req.addr[8:6] == 3'h0);
    end else if (is_bit) begin
      // bit ops stop at 0x1F; extended space is never reachable here
      io_addr = req.addr[5:0];
      addr_ok = (req.addr[8:6] == 3'h0) && (req.addr[5:0] <= IOSSR_BIT_IO_MAX);
    end
    rsvd_sel = addr_ok && ((io_addr == IOSSR_ADDR_PA_IN) || (io_addr == IOSSR_ADDR_PC_IN));
  end

  // one-hot select, one comparator per register
  for (genvar i = 0; i < IOSSR_NUM_REGS; i++) begin : g_sel
    assign sel[i] = addr_ok && (io_addr == REG_ADDR[i]);
  end

  // next state of storage and answer
  always_comb begin
    rsp_next = '0;
    for (int i = 0; i < IOSSR_NUM_REGS; i++) begin
      store_next[i] = store_reg[i];
      if (sel[i]) begin
        rsp_next.hit    = 1'b1;
        rsp_next.rdata  = store_reg[i];
        rsp_next.bitval = store_reg[i][req.bitn];
        unique case (req.op)
          IOSSR_OP_MEM_WR, IOSSR_OP_IO_OUT: begin
            // whole byte stored; no flag bits live here, so no write-one clear
            store_next[i] = req.wdata;
          end
          IOSSR_OP_BIT_SET: begin
            // only the addressed bit changes, others are not rewritten
            store_next[i][req.bitn] = 1'b1;
          end
          IOSSR_OP_BIT_CLR: begin
            store_next[i][req.bitn] = 1'b0;
          end
          default: begin
            // reads and skip tests leave storage alone
          end
        endcase
      end
    end
    // reserved input registers read zero and ignore writes
    if (rsvd_sel) begin
      rsp_next.hit = 1'b1;
    end
    rsp_next.bad = (req.op != IOSSR_OP_NONE) && !addr_ok;
  end

  // register storage and answer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < IOSSR_NUM_REGS; i++) begin
        store_reg[i] <= IOSSR_RESET_VAL;
      end
      rsp_reg <= '0;
    end else begin
      store_reg <= store_next;
      rsp_reg   <= rsp_next;
    end
  end

  assign rsp = rsp_reg;

endmodule

`default_nettype wire

// *** iossr_bank_properties.sv ***
// Purpose: answer checks for the scratch register bank
// Assumes: answer stands one cycle after the taken request
// Notes:   bound into every bank instance below
`timescale 1ns/1ps
`default_nettype none
module iossr_bank_chk
  import iossr_pkg::*;
(
  // clock and reset
  input wire logic       clk,
  input wire logic       rst_n,
  // core access port
  input wire iossr_req_t req,
  input wire iossr_rsp_t rsp
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // request classes shared by several checks
  wire mem = req.op inside {IOSSR_OP_MEM_RD, IOSSR_OP_MEM_WR};
  wire bop = req.op inside {IOSSR_OP_BIT_SET, IOSSR_OP_BIT_CLR, IOSSR_OP_BIT_TST};
  wire s0  = req.addr == 9'h01E;  // first scratch register, bit reachable
  a_idle_quiet:
    assert property (req.op == IOSSR_OP_NONE |=> !rsp.hit && !rsp.bad) else $error("stray answer");
  a_mem_low:
    assert property (mem && req.addr < 9'h020 |=> rsp.bad) else $error("low address taken");
  a_ext_refused:
    assert property (mem && req.addr >= 9'h060 |=> rsp.bad && !rsp.hit) else $error("ext taken");
  a_io_reach:
    assert property (req.op inside {IOSSR_OP_IO_IN, IOSSR_OP_IO_OUT} && req.addr > 9'h03F
      |=> rsp.bad) else $error("in/out beyond reach");
  a_bit_reach:
    assert property (bop && req.addr > 9'h01F |=> rsp.bad && !rsp.hit) else $error("bit op taken");
  a_rsvd_zero:
    assert property (req.op == IOSSR_OP_IO_IN && req.addr == 9'h000 |=> rsp.hit
      && rsp.rdata == 8'h00) else $error("reserved input not zero");
  a_store_back:
    assert property (req.op == IOSSR_OP_IO_OUT && s0 ##1 req.op == IOSSR_OP_IO_IN && s0
      |=> rsp.rdata == $past(req.wdata, 2)) else $error("store lost");
  a_set_only:
    assert property (req.op == IOSSR_OP_BIT_SET && s0 ##1 req.op == IOSSR_OP_IO_IN && s0
      |=> rsp.rdata == ($past(rsp.rdata) | (8'h01 << $past(req.bitn, 2))))
      else $error("bit set touched others");
endmodule
bind iossr_bank iossr_bank_chk i_chk (.clk(clk), .rst_n(rst_n), .req(req), .rsp(rsp));
`default_nettype wire

// *** iossr_core_model.sv ***
// Purpose: core side issuing single accesses
// Assumes: each call starts at a falling edge
// Notes:   calls chain back to back, no idle gap
`timescale 1ns/1ps
`default_nettype none
module iossr_core_model
  import iossr_pkg::*;
(
  input  wire logic       clk,
  output var  iossr_req_t req,
  input  wire iossr_rsp_t rsp
);
  initial req = '0;
  // request stands one cycle; its answer is taken at the next falling edge
  // writes never aim at reserved inputs
  task automatic acc(output iossr_rsp_t r, input iossr_op_t op, input logic [8:0] a,
                     input logic [2:0] b = 3'h0, input logic [7:0] d = 8'h00);
    req = '{op, a, b, d};
    @(negedge clk);
    r = rsp;
  endtask
endmodule
`default_nettype wire

// *** tb_top.sv ***
// Purpose: directed checks of the scratch register bank
// Assumes: refusals are judged by chk on the answer's bad flag and by the bound checker
// Notes:   store pattern is 0x5A xor the i/o address
`timescale 1ns/1ps
`default_nettype none
module tb_top import iossr_pkg::*;;
  logic       clk        = 1'b0;
  logic       rst_n      = 1'b0;
  iossr_req_t req;
  iossr_rsp_t rsp, r;
  int         num_errors = 0;
  int         tests_run  = 0;
  logic [5:0] sa [7]     = '{IOSSR_ADDR_PA_DIR, IOSSR_ADDR_PA_DAT, IOSSR_ADDR_PC_DIR,
    IOSSR_ADDR_PC_DAT, IOSSR_ADDR_SCR0, IOSSR_ADDR_SCR1, IOSSR_ADDR_SCR2};
  always #5 clk = ~clk;
  iossr_bank i_iossr_bank (.clk(clk), .rst_n(rst_n), .req(req), .rsp(rsp));
  iossr_core_model u_core (.clk(clk), .req(req), .rsp(rsp));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // reset value by in, store by out, read back through the data-space alias
  task automatic t_store();
    foreach (sa[i]) begin
      u_core.acc(r, IOSSR_OP_IO_IN, {3'h0, sa[i]});
      chk(r.rdata, IOSSR_RESET_VAL);
      u_core.acc(r, IOSSR_OP_IO_OUT, {3'h0, sa[i]}, 3'h0, 8'h5A ^ {2'h0, sa[i]});
    end
    foreach (sa[i]) begin
      u_core.acc(r, IOSSR_OP_MEM_RD, {3'h0, sa[i]} + IOSSR_DS_OFFSET);
      chk(r.rdata, 8'h5A ^ {2'h0, sa[i]});
    end
    $display("t_store done");
  endtask
  // single-bit set, clear and test on the low scratch register
  task automatic t_bits();
    u_core.acc(r, IOSSR_OP_IO_OUT, 9'h01E, 3'h0, 8'h81);
    u_core.acc(r, IOSSR_OP_IO_IN, 9'h01E);
    u_core.acc(r, IOSSR_OP_BIT_SET, 9'h01E, 3'h3);
    u_core.acc(r, IOSSR_OP_IO_IN, 9'h01E);
    chk(r.rdata, 8'h89);
    u_core.acc(r, IOSSR_OP_BIT_CLR, 9'h01E, 3'h7);
    u_core.acc(r, IOSSR_OP_BIT_TST, 9'h01E, 3'h7);
    chk({7'h00, r.bitval}, 8'h00);
    $display("t_bits done");
  endtask
  // illegal reaches must leave stores alone; reserved input reads zero
  task automatic t_refuse();
    u_core.acc(r, IOSSR_OP_MEM_WR, 9'h01F, 3'h0, 8'hFF);
    chk({7'h00, r.bad}, 8'h01);
    u_core.acc(r, IOSSR_OP_MEM_WR, 9'h060, 3'h0, 8'hFF);
    chk({7'h00, r.bad}, 8'h01);
    u_core.acc(r, IOSSR_OP_IO_OUT, 9'h06A, 3'h0, 8'hFF);
    chk({7'h00, r.bad}, 8'h01);
    u_core.acc(r, IOSSR_OP_BIT_SET, 9'h02A, 3'h0);
    chk({7'h00, r.bad}, 8'h01);
    u_core.acc(r, IOSSR_OP_IO_IN, 9'h000);
    chk({7'h00, r.hit}, 8'h01);
    chk(r.rdata, 8'h00);
    u_core.acc(r, IOSSR_OP_IO_IN, 9'h02A);
    chk({7'h00, r.hit}, 8'h01);
    chk(r.rdata, 8'h5A ^ 8'h2A);
    u_core.acc(r, IOSSR_OP_NONE, 9'h000);
    $display("t_refuse done");
  endtask
  initial begin
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    t_store();
    t_bits();
    t_refuse();
    finish_test();
  end
  // watchdog against a hung run
  initial begin
    #20000;
    num_errors++;
    finish_test();
  end
endmodule
`default_nettype wire
